// >>> rtl/tpm_sequencer.sv
// Microsequencer: step counter, mode, cursor and holding registers
`timescale 1ns/1ps
module tpm_sequencer #(
  parameter int unsigned TIMER_COUNT = tpm_pkg::TIMER_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_strobe,
  input wire logic i_prog_we,
  input wire logic [13:0] i_prog_addr,
  input wire logic [7:0] i_prog_data,
  input wire logic i_kbd_escape,
  input wire logic i_insert_mode,
  input wire logic [7:0] i_input_buffer,
  input wire logic i_input_loaded,
  input wire logic [7:0] i_mem_data,
  input wire logic [7:0] i_lit_data,
  input wire logic i_byte_protected,
  input wire logic i_transmitter_occupied,
  output logic [7:0] o_bus,
  output logic o_mem_write,
  output logic o_tx_load,
  output logic o_aux_send,
  output logic o_main_send_en,
  output logic o_refresh_en,
  output logic o_bell_pulse,
  output logic o_format,
  output logic o_protect,
  output logic o_kbd_disable,
  output logic o_blink,
  output logic [6:0] o_cursor_line,
  output logic [6:0] o_cursor_column,
  output logic [4:0] o_scroll_count,
  output logic [3:0] o_delimiter_rom_address,
  output logic [3:0] o_operation_number,
  output logic o_mode
);
  localparam int unsigned TW = $clog2(TIMER_COUNT + 1);
  typedef struct packed {
    logic [1:0] sync_prot;
    logic [1:0] sync_busy;
    logic [1:0] sync_esc;
    logic [1:0] sync_ins;
    logic [3:0] step_counter;
    logic mode;
    logic [3:0] operation_number;
    logic escape_pending;
    logic [7:0] input_buffer;
    logic [7:0] holding_byte_first;
    logic [7:0] holding_byte_second;
    logic [6:0] cursor_line;
    logic [6:0] cursor_column;
    logic [6:0] saved_line_count;
    logic [6:0] saved_column_count;
    logic line_under;
    logic off_pulse;
    logic [4:0] scroll;
    logic [3:0] delimiter_rom_address;
    logic [2:0] bus_src;
    logic refresh_en;
    logic aux_send;
    logic main_send_en;
    logic format;
    logic protect;
    logic kbd_disable;
    logic blink;
    logic [TW-1:0] timer;
    logic timer_tick;
    logic [3:0] late;
    logic [7:0] bus;
    logic mem_write;
    logic tx_load;
    logic bell_pulse;
  } tpm_seq_s;
  tpm_seq_s s_reg;
  tpm_seq_s s_next;
  tpm_word_if wif ();
  logic [7:0] w;
  logic [7:0] bus_val;
  logic off_screen_flag;
  logic timer_done;
  tpm_decoder u_dec (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_prog_we(i_prog_we),
    .i_prog_addr(i_prog_addr),
    .i_prog_data(i_prog_data),
    .bus(wif.dec)
  );
  function automatic logic [7:0] bus_pick(input logic [2:0] src, input logic [7:0] b,
                                          input logic [7:0] r, input logic [7:0] m,
                                          input logic [7:0] l);
    if (src == tpm_pkg::BUS_SRC_BUF) begin
      bus_pick = b;
    end else if (src == tpm_pkg::BUS_SRC_REG) begin
      bus_pick = r;
    end else if (src == tpm_pkg::BUS_SRC_MEM) begin
      bus_pick = m;
    end else begin
      bus_pick = l;
    end
  endfunction
  assign w = wif.word;
  assign bus_val = bus_pick(s_reg.bus_src, s_reg.input_buffer, s_reg.holding_byte_second,
                            i_mem_data, i_lit_data);
  // Off display, or one-cycle saved cursor underflow pulse
  assign off_screen_flag = (s_reg.cursor_column > tpm_pkg::LAST_COLUMN) ||
                           (s_reg.cursor_line > 7'(tpm_pkg::ROLL_MAX)) ||
                           s_reg.off_pulse;
  // Low while timing, ticks when idle
  assign timer_done = (s_reg.timer == '0) ? s_reg.timer_tick : 1'b0;
  always_comb begin
    wif.term[13:10] = s_reg.step_counter;
    wif.term[8] = s_reg.mode;
    if (s_reg.mode == tpm_pkg::TPM_IDLE) begin
      wif.term[9] = s_reg.escape_pending;
      wif.term[7] = s_reg.sync_ins[1];
      wif.term[6:0] = s_reg.input_buffer[6:0];
    end else begin
      wif.term[9] = s_reg.format;
      wif.term[7] = off_screen_flag;
      wif.term[6:3] = s_reg.operation_number;
      wif.term[2] = timer_done;
      wif.term[1] = s_reg.sync_prot[1] & s_reg.format;
      wif.term[0] = s_reg.sync_busy[1];
    end
  end
  always_comb begin
    s_next = s_reg;
    s_next.sync_prot = {s_reg.sync_prot[0], i_byte_protected};
    s_next.sync_busy = {s_reg.sync_busy[0], i_transmitter_occupied};
    s_next.sync_esc = {s_reg.sync_esc[0], i_kbd_escape};
    s_next.sync_ins = {s_reg.sync_ins[0], i_insert_mode};
    s_next.mem_write = 1'b0;
    s_next.tx_load = 1'b0;
    s_next.bell_pulse = 1'b0;
    s_next.off_pulse = 1'b0;
    s_next.bus = bus_val;
    // 30 ms timer and idle tick
    if (s_reg.timer != '0) begin
      s_next.timer = s_reg.timer - TW'(1);
    end
    s_next.timer_tick = ~s_reg.timer_tick;
    if (i_input_loaded) begin
      s_next.input_buffer = i_input_buffer;
    end
    if (i_strobe) begin
      s_next.step_counter = s_reg.step_counter + 4'h1;
      s_next.late = 4'h0;
      // Deferred group 3 actions
      if (s_reg.late[3]) begin
        s_next.tx_load = 1'b1;
      end
      if (s_reg.late[2] && !i_input_loaded) begin
        s_next.input_buffer = tpm_pkg::NULL_CODE;
      end
      if (s_reg.late[1]) begin
        s_next.cursor_line = '0;
      end
      if (s_reg.late[0]) begin
        s_next.cursor_column = '0;
      end
      if (w[7]) begin
        if (w[6:4] == tpm_pkg::G5_JUMP) begin
          s_next.step_counter = w[3:0];
          s_next.escape_pending = 1'b0;
        end else if (w[6:4] == tpm_pkg::G5_LOAD_OP) begin
          s_next.operation_number = w[3:0];
          s_next.mode = tpm_pkg::TPM_OPER;
          s_next.step_counter = tpm_pkg::STEP_RESET;
        end else if (w[6:4] == tpm_pkg::G5_DELIMITER_ROM_ADDRESS) begin
          s_next.delimiter_rom_address = w[3:0];
        end else if (w[6:4] == tpm_pkg::G5_BUS_SEL) begin
          s_next.bus_src = w[2:0];
          s_next.refresh_en = ~w[3];
        end else if (w[6:4] == tpm_pkg::G5_IDLE) begin
          s_next.mode = tpm_pkg::TPM_IDLE;
          s_next.step_counter = tpm_pkg::STEP_RESET;
          s_next.refresh_en = 1'b1;
          s_next.escape_pending = 1'b0;
        end
      end else if (w[6]) begin
        // Group 1 in low bits
        case (w[2:0])
          tpm_pkg::G1_LOAD_REG: begin
            s_next.holding_byte_second = s_reg.holding_byte_first;
            s_next.holding_byte_first = i_mem_data;
          end
          tpm_pkg::G1_DEC_BLINE: begin
            s_next.saved_line_count = s_reg.saved_line_count - 7'h01;
            if (s_reg.saved_line_count == '0) begin
              s_next.line_under = 1'b1;
            end
          end
          tpm_pkg::G1_DEC_BCOL: begin
            if (s_reg.line_under) begin
              s_next.saved_column_count = s_reg.saved_column_count - 7'h01;
              if (s_reg.saved_column_count == '0) begin
                s_next.off_pulse = 1'b1;
              end
            end
          end
          tpm_pkg::G1_BELL: begin
            s_next.bell_pulse = 1'b1;
          end
          tpm_pkg::G1_CLEAR_REG: begin
            s_next.holding_byte_second = tpm_pkg::NULL_CODE;
            s_next.holding_byte_first = tpm_pkg::SPACE_CODE;
          end
          tpm_pkg::G1_LAST_COL: begin
            s_next.cursor_column = tpm_pkg::LAST_COLUMN;
          end
          tpm_pkg::G1_ROLL: begin
            if (s_reg.scroll == tpm_pkg::ROLL_MAX) begin
              s_next.scroll = '0;
            end else begin
              s_next.scroll = s_reg.scroll + 5'h01;
            end
          end
          default: begin
          end
        endcase
        // Group 2 in bits 5..3, LSB of step picks set or clear
        if (w[5:3] == tpm_pkg::G2_FORMAT) begin
          s_next.format = s_reg.step_counter[0];
        end else if (w[5:3] == tpm_pkg::G2_PROTECT) begin
          s_next.protect = s_reg.step_counter[0];
        end else if (w[5:3] == tpm_pkg::G2_KBD) begin
          s_next.kbd_disable = s_reg.step_counter[0];
        end else if (w[5:3] == tpm_pkg::G2_BLINK) begin
          s_next.blink = s_reg.step_counter[0];
        end else if (w[5:3] == tpm_pkg::G2_TIMER) begin
          s_next.timer = TW'(TIMER_COUNT);
        end
      end else begin
        // Group 3 in low bits, group 4 in bits 5..3
        case (w[2:0])
          tpm_pkg::G3_CLR_BLINE: begin
            s_next.saved_line_count = '0;
            s_next.line_under = 1'b1;
          end
          tpm_pkg::G3_AUX_SEND: begin
            s_next.aux_send = 1'b1;
            s_next.main_send_en = 1'b0;
          end
          tpm_pkg::G3_LOAD_TX: begin
            s_next.late[3] = 1'b1;
          end
          tpm_pkg::G3_CLR_BUF: begin
            s_next.late[2] = 1'b1;
          end
          tpm_pkg::G3_CLR_LINE: begin
            s_next.late[1] = 1'b1;
          end
          tpm_pkg::G3_CLR_COL: begin
            s_next.late[0] = 1'b1;
          end
          tpm_pkg::G3_WRITE: begin
            s_next.mem_write = 1'b1;
          end
          default: begin
          end
        endcase
        case (w[5:3])
          tpm_pkg::G4_INC_LINE: s_next.cursor_line = s_reg.cursor_line + 7'h01;
          tpm_pkg::G4_DEC_LINE: s_next.cursor_line = s_reg.cursor_line - 7'h01;
          tpm_pkg::G4_LOAD_LINE: s_next.cursor_line = bus_val[6:0] - tpm_pkg::LINE_COL_OFFSET;
          tpm_pkg::G4_INC_COL: s_next.cursor_column = s_reg.cursor_column + 7'h01;
          tpm_pkg::G4_DEC_COL: s_next.cursor_column = s_reg.cursor_column - 7'h01;
          tpm_pkg::G4_LOAD_COL: s_next.cursor_column = bus_val[6:0] - tpm_pkg::LINE_COL_OFFSET;
          tpm_pkg::G4_SAVE_CUR: begin
            s_next.saved_column_count = s_reg.cursor_column;
            if (w[2:0] != tpm_pkg::G3_CLR_BLINE) begin
              s_next.saved_line_count = s_reg.cursor_line;
              s_next.line_under = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (s_reg.sync_esc[1] || (i_input_loaded && i_input_buffer == tpm_pkg::ESC_CODE)) begin
      s_next.escape_pending = 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
      s_reg.refresh_en <= 1'b1;
      s_reg.main_send_en <= 1'b1;
      s_reg.bus_src <= tpm_pkg::BUS_SRC_BUF;
    end else begin
      s_reg <= s_next;
    end
  end
  assign o_bus = s_reg.bus;
  assign o_mem_write = s_reg.mem_write;
  assign o_tx_load = s_reg.tx_load;
  assign o_aux_send = s_reg.aux_send;
  assign o_main_send_en = s_reg.main_send_en;
  assign o_refresh_en = s_reg.refresh_en;
  assign o_bell_pulse = s_reg.bell_pulse;
  assign o_format = s_reg.format;
  assign o_protect = s_reg.protect;
  assign o_kbd_disable = s_reg.kbd_disable;
  assign o_blink = s_reg.blink;
  assign o_cursor_line = s_reg.cursor_line;
  assign o_cursor_column = s_reg.cursor_column;
  assign o_scroll_count = s_reg.scroll;
  assign o_delimiter_rom_address = s_reg.delimiter_rom_address;
  assign o_operation_number = s_reg.operation_number;
  assign o_mode = s_reg.mode;
endmodule // tpm_sequencer

// >>> pkg/tpm_pkg.sv
// Shared constants and types for the terminal microsequencer
package tpm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TIMER_MS = 30;
  localparam int unsigned TIMER_CYCLES = (CLK_HZ / 1000) * TIMER_MS;
  localparam logic [6:0] LINE_COL_OFFSET = 7'h20;
  localparam logic [6:0] LAST_COLUMN = 7'h4f;
  localparam logic [4:0] ROLL_MAX = 5'h17;
  localparam logic [7:0] NULL_CODE = 8'h00;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [7:0] ESC_CODE = 8'h1b;
  localparam logic [3:0] STEP_RESET = 4'h0;
  // Group 1 codes, low three bits, bit 7 = 0, bit 6 = 1
  localparam logic [2:0] G1_LOAD_REG = 3'h7;
  localparam logic [2:0] G1_DEC_BLINE = 3'h6;
  localparam logic [2:0] G1_DEC_BCOL = 3'h5;
  localparam logic [2:0] G1_BELL = 3'h4;
  localparam logic [2:0] G1_CLEAR_REG = 3'h3;
  localparam logic [2:0] G1_LAST_COL = 3'h2;
  localparam logic [2:0] G1_ROLL = 3'h1;
  // Group 2 codes, bits 5..3
  localparam logic [2:0] G2_FORMAT = 3'h7;
  localparam logic [2:0] G2_PROTECT = 3'h6;
  localparam logic [2:0] G2_KBD = 3'h5;
  localparam logic [2:0] G2_BLINK = 3'h4;
  localparam logic [2:0] G2_TIMER = 3'h3;
  // Group 3 codes
  localparam logic [2:0] G3_CLR_BLINE = 3'h7;
  localparam logic [2:0] G3_AUX_SEND = 3'h6;
  localparam logic [2:0] G3_LOAD_TX = 3'h5;
  localparam logic [2:0] G3_CLR_BUF = 3'h4;
  localparam logic [2:0] G3_CLR_LINE = 3'h3;
  localparam logic [2:0] G3_CLR_COL = 3'h2;
  localparam logic [2:0] G3_WRITE = 3'h1;
  // Group 4 codes, bits 5..3
  localparam logic [2:0] G4_INC_LINE = 3'h7;
  localparam logic [2:0] G4_DEC_LINE = 3'h6;
  localparam logic [2:0] G4_LOAD_LINE = 3'h5;
  localparam logic [2:0] G4_INC_COL = 3'h4;
  localparam logic [2:0] G4_DEC_COL = 3'h3;
  localparam logic [2:0] G4_LOAD_COL = 3'h2;
  localparam logic [2:0] G4_SAVE_CUR = 3'h1;
  // Group 5 codes, bits 6..4
  localparam logic [2:0] G5_JUMP = 3'h7;
  localparam logic [2:0] G5_LOAD_OP = 3'h6;
  localparam logic [2:0] G5_DELIMITER_ROM_ADDRESS = 3'h5;
  localparam logic [2:0] G5_BUS_SEL = 3'h3;
  localparam logic [2:0] G5_IDLE = 3'h0;
  localparam logic [2:0] BUS_SRC_BUF = 3'h7;
  localparam logic [2:0] BUS_SRC_REG = 3'h6;
  localparam logic [2:0] BUS_SRC_MEM = 3'h5;
  localparam logic [2:0] BUS_SRC_LIT = 3'h4;
  typedef enum logic [0:0] {
    TPM_IDLE = 1'b0,
    TPM_OPER = 1'b1
  } tpm_mode_e;
endpackage

// >>> pkg/tpm_word_if.sv
// Instruction word carrier between decoder and sequencer
`timescale 1ns/1ps
interface tpm_word_if;
  logic [13:0] term;
  logic [7:0] word;
  modport dec (input term, output word);
  modport seq (output term, input word);
endinterface

// >>> rtl/tpm_decoder.sv
// Programmable decode array: fourteen terms to an 8-bit word
`timescale 1ns/1ps
module tpm_decoder #(
  parameter int unsigned TERMS = 16384
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_prog_we,
  input wire logic [13:0] i_prog_addr,
  input wire logic [7:0] i_prog_data,
  tpm_word_if.dec bus
);
  typedef struct packed {
    logic [7:0] word;
  } tpm_dec_s;
  logic [7:0] table_mem [0:TERMS-1];
  tpm_dec_s state_reg;
  tpm_dec_s state_next;
  // Array contents are loaded through the programming port
  always_ff @(posedge i_sys_clk) begin
    if (i_prog_we) begin
      table_mem[i_prog_addr] <= i_prog_data;
    end
  end
  always_comb begin
    state_next = state_reg;
    state_next.word = table_mem[bus.term];
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign bus.word = state_reg.word;
endmodule // tpm_decoder

// >>> sim/tpm_datapath_model.sv
// Behavioural model of the terminal datapath beside the sequencer
`timescale 1ns/1ps
module tpm_datapath_model (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] o_bus,
  input wire logic o_mem_write,
  input wire logic o_tx_load,
  input wire logic o_format,
  input wire logic [6:0] o_cursor_column,
  input wire logic [3:0] o_delimiter_rom_address,
  output logic [7:0] i_mem_data,
  output logic [7:0] i_lit_data,
  output logic i_byte_protected,
  output logic i_transmitter_occupied
);
  localparam logic [7:0] PROT_MAP = 8'h0a;
  logic [7:0] mem [0:7];
  logic [2:0] busy_cnt;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt <= 3'h0;
      for (int k = 0; k < 8; k++) mem[k] <= 8'h30 + 8'(k);
    end else begin
      if (o_mem_write) mem[o_cursor_column[2:0]] <= o_bus;
      if (o_tx_load) busy_cnt <= 3'h5;
      else if (busy_cnt != 3'h0) busy_cnt <= busy_cnt - 3'h1;
    end
  end
  assign i_mem_data = mem[o_cursor_column[2:0]];
  assign i_lit_data = {4'h6, o_delimiter_rom_address};
  assign i_byte_protected = o_format & PROT_MAP[o_cursor_column[2:0]];
  assign i_transmitter_occupied = (busy_cnt != 3'h0);
endmodule // tpm_datapath_model

// >>> sim/tpm_sequencer_asserts.sv
// Port checker for the microsequencer
`timescale 1ns/1ps
module tpm_sequencer_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_strobe,
  input wire logic o_tx_load,
  input wire logic o_aux_send,
  input wire logic o_main_send_en,
  input wire logic o_protect,
  input wire logic o_format,
  input wire logic [6:0] o_cursor_line,
  input wire logic [6:0] o_cursor_column,
  input wire logic [4:0] o_scroll_count,
  input wire logic [3:0] o_delimiter_rom_address,
  input wire logic o_mode
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [2:0] since_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) since_reg <= 3'h7;
    else if (i_strobe) since_reg <= 3'h0;
    else if (since_reg != 3'h7) since_reg <= since_reg + 3'h1;
  end
  chk_scroll_range: assert property (o_scroll_count <= tpm_pkg::ROLL_MAX)
    else $error("scroll count above maximum");
  chk_scroll_step: assert property ($changed(o_scroll_count) |->
    (o_scroll_count == $past(o_scroll_count) + 5'h1) ||
    ($past(o_scroll_count) == tpm_pkg::ROLL_MAX && o_scroll_count == 5'h0))
    else $error("scroll count moved by other than one");
  chk_send_excl: assert property (o_main_send_en == !o_aux_send)
    else $error("main and aux send not exclusive");
  chk_scroll_cause: assert property ($changed(o_scroll_count) |-> since_reg <= 3'h3)
    else $error("scroll changed without strobe");
  chk_column_cause: assert property ($changed(o_cursor_column) |-> since_reg <= 3'h5)
    else $error("column changed without strobe");
  chk_line_cause: assert property ($changed(o_cursor_line) |-> since_reg <= 3'h5)
    else $error("line changed without strobe");
  chk_mode_cause: assert property ($changed(o_mode) |-> since_reg <= 3'h3)
    else $error("mode changed without strobe");
  chk_flop_cause: assert property ($changed(o_protect) || $changed(o_format)
    |-> since_reg <= 3'h3)
    else $error("mode flop changed without strobe");
  chk_lit_cause: assert property ($changed(o_delimiter_rom_address) |-> since_reg <= 3'h3)
    else $error("literal address changed without strobe");
  chk_tx_cause: assert property (o_tx_load |-> since_reg <= 3'h5)
    else $error("transmit load without strobe");
  cov_mode_up: cover property ($rose(o_mode));
  cov_wrap: cover property ($fell(o_scroll_count == tpm_pkg::ROLL_MAX));
  cov_aux: cover property ($rose(o_aux_send));
  cov_tx: cover property (o_tx_load);
endmodule // tpm_sequencer_asserts
bind tpm_sequencer tpm_sequencer_asserts u_asserts (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .i_strobe(i_strobe),
  .o_tx_load(o_tx_load),
  .o_aux_send(o_aux_send),
  .o_main_send_en(o_main_send_en),
  .o_protect(o_protect),
  .o_format(o_format),
  .o_cursor_line(o_cursor_line),
  .o_cursor_column(o_cursor_column),
  .o_scroll_count(o_scroll_count),
  .o_delimiter_rom_address(o_delimiter_rom_address),
  .o_mode(o_mode)
);

// >>> sim/test_terminal_pla_microsequencer.sv
// Self-checking bench for the microsequencer
`timescale 1ns/1ps
module test_terminal_pla_microsequencer;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_strobe = 1'b0, i_prog_we = 1'b0;
  logic [13:0] i_prog_addr = 14'h0;
  logic [7:0] i_prog_data = 8'h0, i_input_buffer = 8'h0;
  logic i_kbd_escape = 1'b0, i_insert_mode = 1'b0, i_input_loaded = 1'b0;
  logic [7:0] i_mem_data, i_lit_data, o_bus;
  logic i_byte_protected, i_transmitter_occupied, o_mem_write, o_tx_load, o_aux_send;
  logic o_main_send_en, o_refresh_en, o_bell_pulse, o_format, o_protect, o_kbd_disable;
  logic o_blink, o_mode;
  logic [6:0] o_cursor_line, o_cursor_column;
  logic [4:0] o_scroll_count;
  logic [3:0] o_delimiter_rom_address, o_operation_number;
  int err_count = 0, n_checks = 0, tx_seen = 0, bell_seen = 0, wr_seen = 0;
  // Idle-mode program by step
  localparam logic [7:0] M0 [0:9] = '{8'h41, 8'h5b, 8'hb6, 8'hb7, 8'h2d,
    8'h70, 8'h70, 8'h42, 8'h06, 8'he9};
  // Idle-mode program after reprogramming
  localparam logic [7:0] M1 [0:5] = '{8'h01, 8'h7c, 8'hbd, 8'h68, 8'h78, 8'h60};
  tpm_sequencer #(.TIMER_COUNT(20)) dut (.*);
  tpm_datapath_model u_model (.*);
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    if (o_tx_load === 1'b1) tx_seen++;
    if (o_bell_pulse === 1'b1) bell_seen++;
    if (o_mem_write === 1'b1) wr_seen++;
  end
  function automatic logic [7:0] word_for(input logic [3:0] s, input logic m, input logic e,
                                          input logic ex);
    if (!m && ex) return (s == 4'h6 && e) ? 8'h41 : ((s < 4'h6) ? M1[s] : 8'h80);
    if (!m) return (s < 4'ha) ? M0[s] : 8'h80;
    case (s)
      4'h0: return 8'hd7;
      4'h1: return 8'h41;
      4'h2: return ex ? 8'h80 : 8'hf1;
      default: return 8'h80;
    endcase
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic prog_table(input logic ex);
    for (int a = 0; a < 16384; a++) begin
      @(negedge i_sys_clk);
      i_prog_we = 1'b1;
      i_prog_addr = 14'(a);
      i_prog_data = word_for(i_prog_addr[13:10], i_prog_addr[8], i_prog_addr[9], ex);
    end
    @(negedge i_sys_clk);
    i_prog_we = 1'b0;
  endtask
  task automatic strobe();
    @(negedge i_sys_clk);
    i_strobe = 1'b1;
    @(negedge i_sys_clk);
    i_strobe = 1'b0;
    repeat (4) @(negedge i_sys_clk);
  endtask
  task automatic give_verdict();
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #500_000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    prog_table(1'b0);
    i_input_buffer = 8'h25;
    i_input_loaded = 1'b1;
    @(negedge i_sys_clk);
    i_input_loaded = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    check("bus_buffer", o_bus, 8'h25);
    check("refresh_en", o_refresh_en, 1'b1);
    strobe();
    check("scroll_one", o_scroll_count, 5'h01);
    strobe();
    strobe();
    check("bus_second_null", o_bus, tpm_pkg::NULL_CODE);
    strobe();
    check("bus_back_buffer", o_bus, 8'h25);
    strobe();
    check("line_loaded", o_cursor_line, 7'h05);
    check("tx_not_yet", 16'(tx_seen), 16'h0000);
    strobe();
    check("protect_set", o_protect, 1'b1);
    check("tx_load_late", 16'(tx_seen), 16'h0001);
    strobe();
    check("protect_clear", o_protect, 1'b0);
    strobe();
    check("last_column", o_cursor_column, tpm_pkg::LAST_COLUMN);
    strobe();
    check("aux_send", o_aux_send, 1'b1);
    check("main_blocked", o_main_send_en, 1'b0);
    strobe();
    check("mode_oper", o_mode, 1'b1);
    check("op_number", o_operation_number, 4'h9);
    strobe();
    check("delimiter_rom_address", o_delimiter_rom_address, 4'h7);
    for (int i = 2; i <= 23; i++) begin
      strobe();
      strobe();
    end
    check("scroll_max", o_scroll_count, 5'h17);
    strobe();
    strobe();
    check("scroll_wrap", o_scroll_count, 5'h00);
    check("still_oper", o_mode, 1'b1);
    prog_table(1'b1);
    strobe();
    strobe();
    check("back_idle", o_mode, 1'b0);
    check("scroll_after", o_scroll_count, 5'h01);
    check("tx_total", 16'(tx_seen), 16'h0001);
    strobe();
    check("write_pulse", 16'(wr_seen), 16'h0001);
    strobe();
    check("bell_pulse", 16'(bell_seen), 16'h0001);
    check("format_set", o_format, 1'b1);
    strobe();
    check("bus_memory", o_bus, 8'h25);
    check("refresh_off", o_refresh_en, 1'b0);
    strobe();
    check("kbd_disabled", o_kbd_disable, 1'b1);
    strobe();
    check("format_clear", o_format, 1'b0);
    strobe();
    check("blink_set", o_blink, 1'b1);
    i_kbd_escape = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    strobe();
    check("escape_roll", o_scroll_count, 5'h02);
    i_kbd_escape = 1'b0;
    strobe();
    check("refresh_back", o_refresh_en, 1'b1);
    check("idle_again", o_mode, 1'b0);
    @(negedge i_sys_clk);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    @(negedge i_sys_clk);
    check("rst_scroll", o_scroll_count, 5'h00);
    check("rst_main_send", o_main_send_en, 1'b1);
    check("rst_refresh", o_refresh_en, 1'b1);
    check("rst_mode", o_mode, 1'b0);
    give_verdict();
  end
endmodule // test_terminal_pla_microsequencer
